// File: hw/scan_port_pkg.sv
// constants for the boundary-scan test port
package scan_port_pkg;
  // instruction register
  localparam int          IR_WIDTH       = 10;
  localparam logic [9:0]  OP_EXTEST      = 10'h00F;
  localparam logic [9:0]  OP_SAMPLE      = 10'h005;
  localparam logic [9:0]  OP_BYPASS      = 10'h3FF;
  localparam logic [9:0]  OP_IDREAD      = 10'h006;
  localparam logic [9:0]  OP_USERCODE    = 10'h007;
  localparam logic [9:0]  OP_CLAMP       = 10'h00A;
  localparam logic [9:0]  OP_HIGHZ       = 10'h00B;
  localparam logic [9:0]  OP_IO_RECONFIG = 10'h00D;
  localparam logic [9:0]  IR_CAPTURE     = 10'h001;
  // identification code layout
  localparam int          ID_WIDTH       = 32;
  localparam int          ID_VER_LSB     = 28;
  localparam int          ID_PART_LSB    = 12;
  localparam int          ID_MFR_LSB     = 1;
  localparam logic        ID_FIXED_ONE   = 1'b1;
  // boundary-scan lengths per variant
  localparam int          BSR_LEN_SMALL  = 1506;
  localparam int          BSR_LEN_MID_A  = 2274;
  localparam int          BSR_LEN_MID_B  = 2682;
  localparam int          BSR_LEN_MID_C  = 2970;
  localparam int          BSR_LEN_LARGE  = 3402;
  localparam int          SYNC_STAGES    = 2;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_e;
endpackage

// File: hw/pin_sync.sv
// two-flop synchroniser for a group of external pins
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] init_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= d_i;
      stage2 <= stage1;
    end
  end
  // init_i selects a safe idle level per bit without a reset-time port load
  assign q_o = stage2 ^ init_i;
endmodule

// File: hw/boundary_scan_test_port.sv
// boundary-scan test access port with id, bypass and boundary register
module boundary_scan_test_port #(
  parameter int          BSR_LEN        = scan_port_pkg::BSR_LEN_MID_B,
  parameter int          BSR_LEN_BIGPKG = scan_port_pkg::BSR_LEN_MID_C,
  parameter logic [3:0]  VERSION        = 4'h0,
  parameter logic [15:0] PART_NUM       = 16'h1234, // arbitrary value
  parameter logic [15:0] PART_NUM_BIG   = 16'h1235, // arbitrary value
  parameter logic [15:0] PART_NUM_ES    = 16'h1200, // arbitrary value
  parameter logic [10:0] MFR_ID         = 11'h155,  // arbitrary value
  parameter logic [31:0] USER_CODE      = 32'hFFFFFFFF
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  input  wire logic        trst_n_i,
  input  wire logic        big_package_i,
  input  wire logic        engineering_sample_i,
  input  wire logic        config_request_n_i,
  input  wire logic        config_status_n_i,
  input  wire logic        configuring_i,
  input  wire logic [3:0]  user_pin_in_i,
  input  wire logic [3:0]  core_out_i,
  input  wire logic [3:0]  core_oe_n_i,
  output logic             tdo_o,
  output logic             tdo_oe_n_o,
  output logic [3:0]       user_pin_out_o,
  output logic [3:0]       user_pin_oe_n_o,
  output logic             config_abort_o,
  output logic             id_valid_o
);
  localparam int LEN = 16'(BSR_LEN) > 16'(BSR_LEN_BIGPKG) ? BSR_LEN : BSR_LEN_BIGPKG;
  localparam int PINS = 4;

  // tap pins and config status are synchronised here; user_pin_in_i, configuring_i and the package and sample straps are read directly
  logic [4:0] pin_q;
  pin_sync #(.W(5)) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({tck_i, tms_i, tdi_i, ~trst_n_i, config_status_n_i}),
    .init_i  (5'h00),
    .q_o     (pin_q)
  );
  // flops clear to zero: tck low, trst inactive, status read as not ready until synced
  logic tck_s, tms_s, tdi_s, trst_s, cfg_ok;
  assign tck_s  = pin_q[4];
  assign tms_s  = pin_q[3];
  assign tdi_s  = pin_q[2];
  assign trst_s = pin_q[1];
  assign cfg_ok = pin_q[0];

  // status already passes the shared synchroniser; only the request needs its own pair
  logic cfg_req_q1, cfg_req_q2;
  logic tck_d, rise, fall;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_req_q1 <= 1'b0;
      cfg_req_q2 <= 1'b0;
      tck_d      <= 1'b0;
    end else begin
      cfg_req_q1 <= config_request_n_i;
      cfg_req_q2 <= cfg_req_q1;
      tck_d      <= tck_s;
    end
  end
  assign rise = tck_s & ~tck_d;
  assign fall = ~tck_s & tck_d;

  // selected id code, laid out msb first with the fixed one at bit zero
  function automatic logic [31:0] id_word(input logic big, input logic es);
    logic [15:0] part;
    part = es ? PART_NUM_ES : (big ? PART_NUM_BIG : PART_NUM);
    return {VERSION, part, MFR_ID, scan_port_pkg::ID_FIXED_ONE};
  endfunction

  function automatic logic ir_is(input logic [9:0] ir, input logic [9:0] op);
    return ir == op;
  endfunction

  scan_port_pkg::tap_state_e state, next_state;
  logic [9:0]  ir_sh, next_ir_sh, ir, next_ir;
  logic [31:0] dr_id, next_dr_id;
  logic        byp, next_byp;
  logic [LEN-1:0] bsr, next_bsr;
  logic [PINS-1:0] upd, next_upd;
  logic        tdo, next_tdo, tdo_en, next_tdo_en;
  logic        io_reconf, next_io_reconf;
  logic        in_cfg;
  int unsigned bsr_used;

  // scan works regardless of configuration; config only limits instructions
  assign in_cfg   = configuring_i & ~io_reconf;
  assign bsr_used = big_package_i ? BSR_LEN_BIGPKG : BSR_LEN;

  // instructions acting on pins are held off during configuration
  function automatic logic [9:0] gate_op(input logic [9:0] op, input logic cfg);
    if (!cfg || op == scan_port_pkg::OP_BYPASS || op == scan_port_pkg::OP_IDREAD ||
        op == scan_port_pkg::OP_SAMPLE || op == scan_port_pkg::OP_IO_RECONFIG)
      return op;
    return scan_port_pkg::OP_BYPASS;
  endfunction

  always_comb begin
    next_state     = state;
    next_ir_sh     = ir_sh;
    next_ir        = ir;
    next_dr_id     = dr_id;
    next_byp       = byp;
    next_bsr       = bsr;
    next_upd       = upd;
    next_tdo       = tdo;
    next_tdo_en    = tdo_en;
    next_io_reconf = io_reconf & configuring_i;
    if (rise) begin
      unique case (state)
        scan_port_pkg::TLR:    next_state = tms_s ? scan_port_pkg::TLR : scan_port_pkg::RTI;
        scan_port_pkg::RTI:    next_state = tms_s ? scan_port_pkg::SEL_DR : scan_port_pkg::RTI;
        scan_port_pkg::SEL_DR: next_state = tms_s ? scan_port_pkg::SEL_IR : scan_port_pkg::CAP_DR;
        scan_port_pkg::CAP_DR: next_state = tms_s ? scan_port_pkg::EX1_DR : scan_port_pkg::SH_DR;
        scan_port_pkg::SH_DR:  next_state = tms_s ? scan_port_pkg::EX1_DR : scan_port_pkg::SH_DR;
        scan_port_pkg::EX1_DR: next_state = tms_s ? scan_port_pkg::UPD_DR : scan_port_pkg::PA_DR;
        scan_port_pkg::PA_DR:  next_state = tms_s ? scan_port_pkg::EX2_DR : scan_port_pkg::PA_DR;
        scan_port_pkg::EX2_DR: next_state = tms_s ? scan_port_pkg::UPD_DR : scan_port_pkg::SH_DR;
        scan_port_pkg::UPD_DR: next_state = tms_s ? scan_port_pkg::SEL_DR : scan_port_pkg::RTI;
        scan_port_pkg::SEL_IR: next_state = tms_s ? scan_port_pkg::TLR : scan_port_pkg::CAP_IR;
        scan_port_pkg::CAP_IR: next_state = tms_s ? scan_port_pkg::EX1_IR : scan_port_pkg::SH_IR;
        scan_port_pkg::SH_IR:  next_state = tms_s ? scan_port_pkg::EX1_IR : scan_port_pkg::SH_IR;
        scan_port_pkg::EX1_IR: next_state = tms_s ? scan_port_pkg::UPD_IR : scan_port_pkg::PA_IR;
        scan_port_pkg::PA_IR:  next_state = tms_s ? scan_port_pkg::EX2_IR : scan_port_pkg::PA_IR;
        scan_port_pkg::EX2_IR: next_state = tms_s ? scan_port_pkg::UPD_IR : scan_port_pkg::SH_IR;
        scan_port_pkg::UPD_IR: next_state = tms_s ? scan_port_pkg::SEL_DR : scan_port_pkg::RTI;
      endcase
      unique case (state)
        scan_port_pkg::TLR: next_ir = scan_port_pkg::OP_IDREAD;
        scan_port_pkg::CAP_IR: next_ir_sh = scan_port_pkg::IR_CAPTURE;
        scan_port_pkg::SH_IR:  next_ir_sh = {tdi_s, ir_sh[9:1]};
        scan_port_pkg::UPD_IR: begin
          next_ir = gate_op(ir_sh, in_cfg);
          if (ir_sh == scan_port_pkg::OP_IO_RECONFIG && configuring_i)
            next_io_reconf = 1'b1;
        end
        scan_port_pkg::CAP_DR: begin
          // id may be stale while config is held in reset; controller reads it later
          if (ir_is(ir, scan_port_pkg::OP_IDREAD))
            next_dr_id = id_word(big_package_i, engineering_sample_i);
          else if (ir_is(ir, scan_port_pkg::OP_USERCODE))
            next_dr_id = USER_CODE;
          next_byp = 1'b0;
          if (ir_is(ir, scan_port_pkg::OP_SAMPLE) || ir_is(ir, scan_port_pkg::OP_EXTEST))
            next_bsr[PINS-1:0] = user_pin_in_i;
        end
        scan_port_pkg::SH_DR: begin
          next_dr_id = {tdi_s, dr_id[31:1]};
          next_byp   = tdi_s;
          next_bsr   = bsr >> 1;
          next_bsr[bsr_used-1] = tdi_s;
        end
        scan_port_pkg::UPD_DR:
          if (ir_is(ir, scan_port_pkg::OP_SAMPLE) || ir_is(ir, scan_port_pkg::OP_EXTEST))
            next_upd = bsr[PINS-1:0];
        default: ;
      endcase
      if (trst_s)
        next_state = scan_port_pkg::TLR;
    end
    if (fall) begin
      next_tdo_en = (state == scan_port_pkg::SH_DR) || (state == scan_port_pkg::SH_IR);
      if (state == scan_port_pkg::SH_IR)
        next_tdo = ir_sh[0];
      else if (ir_is(ir, scan_port_pkg::OP_IDREAD) || ir_is(ir, scan_port_pkg::OP_USERCODE))
        next_tdo = dr_id[0];
      else if (ir_is(ir, scan_port_pkg::OP_SAMPLE) || ir_is(ir, scan_port_pkg::OP_EXTEST))
        next_tdo = bsr[0];
      else
        next_tdo = byp;
    end
    if (trst_s && !rise) begin
      next_state = scan_port_pkg::TLR;
      next_ir    = scan_port_pkg::OP_IDREAD;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= scan_port_pkg::TLR;
      ir_sh     <= '0;
      ir        <= scan_port_pkg::OP_IDREAD;
      dr_id     <= '0;
      byp       <= 1'b0;
      bsr       <= '0;
      upd       <= '0;
      tdo       <= 1'b0;
      tdo_en    <= 1'b0;
      io_reconf <= 1'b0;
    end else begin
      state     <= next_state;
      ir_sh     <= next_ir_sh;
      ir        <= next_ir;
      dr_id     <= next_dr_id;
      byp       <= next_byp;
      bsr       <= next_bsr;
      upd       <= next_upd;
      tdo       <= next_tdo;
      tdo_en    <= next_tdo_en;
      io_reconf <= next_io_reconf;
    end
  end

  // pin drive: highz/clamp/extest override core; configuring tristates all
  logic [PINS-1:0] next_pin_out, next_pin_oe_n, pin_out, pin_oe_n;
  always_comb begin
    next_pin_out  = core_out_i;
    next_pin_oe_n = core_oe_n_i;
    if (ir_is(ir, scan_port_pkg::OP_EXTEST) || ir_is(ir, scan_port_pkg::OP_CLAMP)) begin
      next_pin_out  = upd;
      next_pin_oe_n = '0;
    end
    if (ir_is(ir, scan_port_pkg::OP_HIGHZ) || configuring_i)
      next_pin_oe_n = '1;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  assign tdo_o           = tdo;
  assign tdo_oe_n_o      = ~tdo_en;
  assign user_pin_out_o  = pin_out;
  assign user_pin_oe_n_o = pin_oe_n;
  assign config_abort_o  = io_reconf;
  assign id_valid_o      = cfg_req_q2 & cfg_ok;
endmodule

// File: sim/boundary_scan_test_port_properties.sv
// pin-level assertions for the boundary-scan test port
module boundary_scan_test_port_checker (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       tck_i,
  input wire logic       trst_n_i,
  input wire logic       config_request_n_i,
  input wire logic       config_status_n_i,
  input wire logic       configuring_i,
  input wire logic       tdo_o,
  input wire logic       tdo_oe_n_o,
  input wire logic [3:0] user_pin_oe_n_o,
  input wire logic       config_abort_o,
  input wire logic       id_valid_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_cfg_held;
    (configuring_i && !config_abort_o)[*3];
  endsequence
  sequence s_cfg_ok;
    (config_request_n_i && config_status_n_i)[*5];
  endsequence
  property p_cfg_hiz;
    s_cfg_held |-> user_pin_oe_n_o == 4'hF;
  endproperty
  property p_status_low;
    $fell(config_status_n_i) |-> ##[1:4] !id_valid_o;
  endproperty
  property p_req_low;
    $fell(config_request_n_i) |-> ##[1:4] !id_valid_o;
  endproperty
  property p_valid;
    s_cfg_ok |-> id_valid_o;
  endproperty
  // tdo may only move while tck is low, so the controller samples it settled
  property p_tdo_fall;
    $changed(tdo_o) |-> !tck_i;
  endproperty
  property p_trst_idle;
    !trst_n_i [*5] |-> tdo_oe_n_o;
  endproperty
  property p_reset_rel;
    $rose(rst_n_i) |-> tdo_oe_n_o && user_pin_oe_n_o == 4'hF;
  endproperty
  property p_abort;
    $rose(config_abort_o) |-> $past(configuring_i);
  endproperty
  a_cfg_hiz: assert property (p_cfg_hiz) else $error("user pins driven while configuring");
  a_status_low: assert property (p_status_low) else $error("id valid with status low");
  a_req_low: assert property (p_req_low) else $error("id valid with request low");
  a_valid: assert property (p_valid) else $error("id not valid with config high");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved while tck high");
  a_trst_idle: assert property (p_trst_idle) else $error("tdo enabled during test reset");
  a_reset_rel: assert property (p_reset_rel) else $error("outputs enabled out of reset");
  a_abort: assert property (p_abort) else $error("abort without configuration");
endmodule
bind boundary_scan_test_port boundary_scan_test_port_checker chk_i (.mclk_i, .rst_n_i, .tck_i,
  .trst_n_i, .config_request_n_i, .config_status_n_i, .configuring_i, .tdo_o, .tdo_oe_n_o,
  .user_pin_oe_n_o, .config_abort_o, .id_valid_o);

// File: sim/jtag_tester.sv
// serial test controller model driving the scan port pins
module jtag_tester (
  input  wire logic mclk_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b1;
  end
  // tck rests low between frames; tms and tdi fall back to their pull-up level
  task automatic bit_io(input logic ms, input logic di, output logic dq);
    @(posedge mclk_i);
    tms_o <= ms;
    tdi_o <= di;
    repeat (8) @(posedge mclk_i);
    dq = tdo_i;
    tck_o <= 1'b1;
    repeat (8) @(posedge mclk_i);
    tck_o <= 1'b0;
    tms_o <= 1'b1;
    tdi_o <= 1'b1;
  endtask
  task automatic walk(input logic [7:0] pat, input int n);
    logic q;
    for (int i = 0; i < n; i++) bit_io(pat[i], 1'b1, q);
  endtask
  task automatic go_idle;
    walk(8'h1F, 6);
  endtask
  task automatic pulse_trst;
    @(posedge mclk_i);
    trst_n_o <= 1'b0;
    repeat (8) @(posedge mclk_i);
    trst_n_o <= 1'b1;
  endtask
  task automatic shift_ir(input logic [9:0] op, output logic [9:0] cap);
    walk(8'h03, 4);
    for (int i = 0; i < scan_port_pkg::IR_WIDTH; i++) bit_io(i == 9, op[i], cap[i]);
    walk(8'h01, 2);
  endtask
  task automatic shift_dr(input int n, input logic [31:0] din, output logic [31:0] dout,
                          output logic [1:0] tail);
    logic q;
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, (i < 32) && din[i % 32], q);
      if (i < 32) dout[i % 32] = q;
      tail = {q, tail[1]};
    end
    walk(8'h01, 2);
  endtask
endmodule

// File: sim/boundary_scan_test_port_bench.sv
// self-checking bench for the boundary-scan test port
module boundary_scan_test_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0]  VER = 4'h3;         // arbitrary
  localparam logic [15:0] PN  = 16'hA5C3;     // arbitrary
  localparam logic [15:0] PNB = 16'h5A3C;     // arbitrary
  localparam logic [15:0] PNE = 16'h0F0F;     // arbitrary
  localparam logic [10:0] MFR = 11'h2B7;      // arbitrary
  localparam logic [31:0] UC  = 32'hC0DE1234;
  localparam int          LS  = scan_port_pkg::BSR_LEN_SMALL;
  logic mclk, rst_n, tck, tms, tdi, trst_n, big, es, req_n, stat_n, cfg, tdo, abort, valid;
  logic [3:0] pin_in, core_out, core_oe_n, pin_out, pin_oe_n;
  logic [31:0] d;
  logic [9:0] c;
  logic [1:0] t;
  int n_errors;
  int checked;
  boundary_scan_test_port #(.BSR_LEN(LS), .VERSION(VER), .PART_NUM(PN), .PART_NUM_BIG(PNB),
    .PART_NUM_ES(PNE), .MFR_ID(MFR), .USER_CODE(UC)) DUT (.mclk_i(mclk), .rst_n_i(rst_n),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .big_package_i(big),
    .engineering_sample_i(es), .config_request_n_i(req_n), .config_status_n_i(stat_n),
    .configuring_i(cfg), .user_pin_in_i(pin_in), .core_out_i(core_out),
    .core_oe_n_i(core_oe_n), .tdo_o(tdo), .tdo_oe_n_o(), .user_pin_out_o(pin_out),
    .user_pin_oe_n_o(pin_oe_n), .config_abort_o(abort), .id_valid_o(valid));
  jtag_tester jt (.mclk_i(mclk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .trst_n_o(trst_n));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_idcode;
    jt.shift_ir(scan_port_pkg::OP_IDREAD, c);
    chk("ir capture", 32'(scan_port_pkg::IR_CAPTURE), 32'(c));
    jt.shift_dr(32, '0, d, t);
    chk("idcode", {VER, PN, MFR, 1'b1}, d);
    jt.shift_ir(scan_port_pkg::OP_BYPASS, c);
    jt.pulse_trst();
    jt.go_idle();
    jt.shift_dr(32, '0, d, t);
    chk("id after trst", {VER, PN, MFR, 1'b1}, d);
    @(posedge mclk);
    big <= 1'b1;
    jt.shift_dr(32, '0, d, t);
    chk("big id", {VER, PNB, MFR, 1'b1}, d);
    big <= 1'b0;
    es <= 1'b1;
    jt.shift_dr(32, '0, d, t);
    chk("sample id", {VER, PNE, MFR, 1'b1}, d);
    es <= 1'b0;
  endtask
  // the far ends of the chain are checked with a marker bit; the middle is not seen
  task automatic t_length;
    jt.shift_ir(scan_port_pkg::OP_SAMPLE, c);
    jt.shift_dr(LS + 2, 32'h1, d, t);
    chk("small length", 32'h1, 32'(t));
    big <= 1'b1;
    jt.shift_ir(scan_port_pkg::OP_EXTEST, c);
    jt.shift_dr(scan_port_pkg::BSR_LEN_MID_C + 2, 32'h1, d, t);
    chk("big length", 32'h1, 32'(t));
    big <= 1'b0;
  endtask
  task automatic t_bypass;
    logic [9:0] ops [3] = '{scan_port_pkg::OP_BYPASS, scan_port_pkg::OP_CLAMP,
                            scan_port_pkg::OP_HIGHZ};
    core_oe_n <= 4'h0;
    foreach (ops[i]) begin
      jt.shift_ir(ops[i], c);
      jt.shift_dr(8, 32'hB5, d, t);
      chk("bypass path", 32'h6A, 32'(d[7:0]));
    end
    chk("highz pins", 32'hF, 32'(pin_oe_n));
    jt.shift_ir(scan_port_pkg::OP_USERCODE, c);
    jt.shift_dr(32, '0, d, t);
    chk("usercode", UC, d);
  endtask
  task automatic t_config;
    jt.shift_ir(scan_port_pkg::OP_SAMPLE, c);
    chk("user drive", 32'h9, 32'({pin_oe_n, pin_out}));
    cfg <= 1'b1;
    jt.shift_ir(scan_port_pkg::OP_EXTEST, c);
    chk("cfg tristate", 32'hF, 32'(pin_oe_n));
    jt.shift_dr(8, 32'hB5, d, t);
    chk("refused op", 32'h6A, 32'(d[7:0]));
    t_idcode();
    jt.shift_ir(scan_port_pkg::OP_IO_RECONFIG, c);
    chk("abort", 32'h1, 32'(abort));
    cfg <= 1'b0;
  endtask
  task automatic t_status;
    stat_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("status low", 32'h0, 32'(valid));
    stat_n <= 1'b1;
    req_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("request low", 32'h0, 32'(valid));
    req_n <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("id valid", 32'h1, 32'(valid));
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (95000) @(posedge mclk);
    n_errors++;
    conclude();
  end
  initial begin
    {rst_n, big, es, cfg} = 4'h0;
    {req_n, stat_n} = 2'b11;
    pin_in = 4'h6;
    core_out = 4'h9;
    core_oe_n = 4'hF;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    jt.go_idle();
    t_idcode();
    t_bypass();
    t_config();
    t_status();
    t_length();
    conclude();
  end
endmodule
